//--- core/icc_top.sv
// one input capture channel with its own 16-bit counter, behind AXI4-Lite
// assumes source and timer ticks are one-cycle pulses on aclk; the pin is async
//
// Function
// - idle-stop bit halts channel during idle
// - clock select picks counter clock source
// - timer one clock used synchronously only
// - interrupt after one to four captures
// - capture count ignored in modes 001/111
// - read-only overflow flag set on overflow
// - read-only not-empty flag tracks buffer
// - four-entry first-in first-out capture buffer
// - mode 111 is rising-edge wake interrupt
// - prescaled modes capture every 4th/16th rise
// - simple modes capture every rise or fall
// - mode 001 captures both edges
// - modes 000 and 110 disable channel
// - both cascade bits set join pair
// - trigger bit picks start or sync
// - untriggered counter held at zero
// - source sets trigger status, software too
// - source select default timer three
// - codes pick capture, event, compare sources
// - private 16-bit counter as time base
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "icc_map.svh"
module icc_top
   import icc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // capture pin and processor state
   input wire logic capture_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   // time base ticks and sync/trigger sources
   input wire icc_pkg::icc_srcs_s srcs,
   // cascade with the adjacent channel
   input wire logic partner_cascade,
   input wire logic upper_half,
   input wire logic cascade_carry_in,
   output logic cascade_en_out,
   output logic cascade_carry,
   // interrupt request pulse
   output logic capture_irq
);
   import icc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers

   // code bit 2 marks a mapped word, bits 1:0 the register
   function automatic logic [2:0] reg_dec(input logic [7:0] a);
      logic [7:0] al;
      begin
         al = {a[7:2], 2'h0};
         case (al)
            `ICC_OFF_CTRL1: reg_dec = 3'h4;
            `ICC_OFF_CTRL2: reg_dec = 3'h5;
            `ICC_OFF_BUF: reg_dec = 3'h6;
            `ICC_OFF_CNT: reg_dec = 3'h7;
            default: reg_dec = 3'h0;
         endcase
      end
   endfunction

   // timer one arrives as a synchronous tick only, never its async form
   function automatic logic clk_tick(input logic [2:0] s, input icc_srcs_s v);
      begin
         case (s)
            `ICC_CK_PCLK: clk_tick = 1'b1;
            `ICC_CK_T1: clk_tick = v.t1;
            `ICC_CK_T2: clk_tick = v.t2;
            `ICC_CK_T3: clk_tick = v.t3;
            `ICC_CK_T4: clk_tick = v.t4;
            `ICC_CK_T5: clk_tick = v.t5;
            default: clk_tick = 1'b0;
         endcase
      end
   endfunction

   // 00000, 11111 and reserved codes select nothing
   function automatic logic src_hit(input logic [4:0] s, input icc_srcs_s v);
      logic [4:0] k;
      begin
         src_hit = 1'b0;
         k = 5'h0;
         if (s >= `ICC_S_OC1 && s <= `ICC_S_OC4)
         begin
            k = s - `ICC_S_OC1;
            src_hit = v.oc_evt[k[1:0]];
         end
         else if (s >= `ICC_S_IC1 && s <= `ICC_S_IC4)
         begin
            k = s - `ICC_S_IC1;
            src_hit = v.ic_evt[k[1:0]];
         end
         else if (s >= `ICC_S_II1 && s <= `ICC_S_II4)
         begin
            k = s - `ICC_S_II1;
            src_hit = v.ic_int[k[1:0]];
         end
         else if (s >= `ICC_S_COMPARATOR_ONE && s <= `ICC_S_CMP4)
         begin
            k = s - `ICC_S_COMPARATOR_ONE;
            src_hit = v.cmp_evt[k[1:0]];
         end
         else if (s == `ICC_S_T1)
            src_hit = v.t1;
         else if (s == `ICC_S_T2)
            src_hit = v.t2;
         else if (s == `ICC_S_T3)
            src_hit = v.t3;
         else if (s == `ICC_S_T4)
            src_hit = v.t4;
         else if (s == `ICC_S_T5)
            src_hit = v.t5;
      end
   endfunction

   // byte-lane merge restricted to the writable bits
   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] d, input logic [1:0] s, input logic [15:0] wm);
      logic [15:0] m;
      begin
         m = {{8{s[1]}}, {8{s[0]}}} & wm;
         merge = (old & ~m) | (d & m);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state and decoded conditions

   icc_state_s st_ff;
   icc_state_s nxt_st;
   logic [2:0] mode;
   logic halted;
   logic mode_on;
   logic run;
   logic trig_op;
   logic tstat;
   logic casc_on;
   logic tick;
   logic evt;
   logic rise;
   logic fall;
   logic [3:0] pre_last;
   logic prescaled;
   logic cap;
   logic full;
   logic push;
   logic pop;
   logic ar_hit;
   logic [2:0] rd_code;
   logic [2:0] wr_code;
   logic do_wr;
   logic [15:0] rd_ctrl1;

   assign mode = st_ff.ctrl1[`ICC_C1_MODE];
   assign halted = st_ff.ctrl1[`ICC_C1_STOP] & cpu_idle;
   assign mode_on = mode != `ICC_M_OFF && mode != `ICC_M_UNUSED
      && mode != `ICC_M_WAKE;
   assign run = mode_on & ~halted;
   assign trig_op = st_ff.ctrl2[`ICC_C2_TRIG];
   assign tstat = st_ff.ctrl2[`ICC_C2_TSTAT];
   // the pair joins only when both channels ask for it
   assign casc_on = st_ff.ctrl2[`ICC_C2_CASC] & partner_cascade;
   assign tick = (casc_on & upper_half) ? cascade_carry_in
      : clk_tick(st_ff.ctrl1[`ICC_C1_CSEL], srcs);
   assign evt = src_hit(st_ff.ctrl2[`ICC_C2_SYNC], srcs);
   assign rise = st_ff.pin_sync & ~st_ff.pin_prev;
   assign fall = ~st_ff.pin_sync & st_ff.pin_prev;
   assign prescaled = mode == `ICC_M_PRE4 || mode == `ICC_M_PRE16;
   assign pre_last = (mode == `ICC_M_PRE4) ? `ICC_PRE4_LAST : `ICC_PRE16_LAST;
   assign cap = run & ((mode == `ICC_M_EDGE & (rise | fall))
      | (mode == `ICC_M_FALL & fall) | (mode == `ICC_M_RISE & rise)
      | (prescaled & rise & st_ff.pre == pre_last));
   assign full = st_ff.count == `ICC_DEPTH;
   assign push = cap & ~full;
   assign ar_hit = arvalid & st_ff.arready;
   assign rd_code = reg_dec(araddr);
   assign wr_code = reg_dec(st_ff.awaddr);
   assign pop = ar_hit & rd_code == 3'h6 & st_ff.count != 3'h0;
   assign do_wr = st_ff.aw_hold & st_ff.w_hold & ~st_ff.bvalid;

   always_comb
   begin
      rd_ctrl1 = st_ff.ctrl1;
      rd_ctrl1[`ICC_C1_OVF] = st_ff.ovf;
      rd_ctrl1[`ICC_C1_NE] = st_ff.count != 3'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      nxt_st = st_ff;
      // pin passes two flops before any edge logic sees it
      nxt_st.pin_meta = capture_pin;
      nxt_st.pin_sync = st_ff.pin_meta;
      nxt_st.pin_prev = st_ff.pin_sync;
      nxt_st.irq = 1'b0;
      nxt_st.carry = 1'b0;
      nxt_st.casc = st_ff.ctrl2[`ICC_C2_CASC];

      // counter: trigger mode holds at zero until started
      if (run)
      begin
         if (trig_op & ~tstat)
            nxt_st.cnt = 16'h0000;
         else if (~trig_op & evt)
            nxt_st.cnt = 16'h0000;
         else if (tick)
         begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
            nxt_st.carry = st_ff.cnt == 16'hffff;
         end
      end
      else if (~halted)
         nxt_st.cnt = 16'h0000;

      // prescaler counts rising edges only in prescaled modes
      if (~prescaled | ~mode_on)
         nxt_st.pre = 4'h0;
      else if (run & rise)
         nxt_st.pre = (st_ff.pre == pre_last) ? 4'h0 : st_ff.pre + 4'h1;

      // capture buffer; a full buffer keeps its oldest entries
      if (push)
         nxt_st.mem[st_ff.rd_ptr + st_ff.count[1:0]] = st_ff.cnt;
      if (pop)
         nxt_st.rd_ptr = st_ff.rd_ptr + 2'h1;
      nxt_st.count = st_ff.count + {2'h0, push} - {2'h0, pop};
      if (pop & st_ff.count == 3'h1)
         nxt_st.ovf = 1'b0;
      if (cap & full)
         nxt_st.ovf = 1'b1;

      // captures per interrupt, ignored in both-edge mode
      if (cap)
      begin
         if (mode == `ICC_M_EDGE
            || st_ff.icnt == st_ff.ctrl1[`ICC_C1_ICI])
         begin
            nxt_st.irq = 1'b1;
            nxt_st.icnt = 2'h0;
         end
         else
            nxt_st.icnt = st_ff.icnt + 2'h1;
      end
      // wake mode: rising edge interrupt in sleep or idle, nothing else
      if (mode == `ICC_M_WAKE & rise & (cpu_sleep | cpu_idle))
         nxt_st.irq = 1'b1;

      // turning the channel off flushes it
      if (~mode_on)
      begin
         nxt_st.count = 3'h0;
         nxt_st.rd_ptr = 2'h0;
         nxt_st.ovf = 1'b0;
         nxt_st.icnt = 2'h0;
      end

      // bus write channels
      if (awvalid & st_ff.awready)
      begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.awaddr = awaddr;
      end
      if (wvalid & st_ff.wready)
      begin
         nxt_st.w_hold = 1'b1;
         nxt_st.wdata = wdata[15:0];
         nxt_st.wstrb = wstrb[1:0];
      end
      if (st_ff.bvalid & bready)
         nxt_st.bvalid = 1'b0;
      if (do_wr)
      begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = wr_code[2] ? `ICC_RESP_OK : `ICC_RESP_ERR;
         if (wr_code == 3'h4)
            nxt_st.ctrl1 = merge(st_ff.ctrl1, st_ff.wdata, st_ff.wstrb,
               `ICC_C1_WMASK);
         if (wr_code == 3'h5)
            nxt_st.ctrl2 = merge(st_ff.ctrl2, st_ff.wdata, st_ff.wstrb,
               `ICC_C2_WMASK);
      end
      // source event sets trigger status after any software write
      if (run & trig_op & evt)
         nxt_st.ctrl2[`ICC_C2_TSTAT] = 1'b1;
      nxt_st.awready = ~nxt_st.aw_hold & ~nxt_st.bvalid;
      nxt_st.wready = ~nxt_st.w_hold & ~nxt_st.bvalid;

      // bus read channel; reading the buffer word pops it
      if (st_ff.rvalid & rready)
         nxt_st.rvalid = 1'b0;
      if (ar_hit)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = rd_code[2] ? `ICC_RESP_OK : `ICC_RESP_ERR;
         case (rd_code)
            3'h4: nxt_st.rdata = {16'h0000, rd_ctrl1};
            3'h5: nxt_st.rdata = {16'h0000, st_ff.ctrl2};
            3'h6: nxt_st.rdata = {16'h0000, st_ff.mem[st_ff.rd_ptr]};
            3'h7: nxt_st.rdata = {16'h0000, st_ff.cnt};
            default: nxt_st.rdata = 32'h0000_0000;
         endcase
      end
      nxt_st.arready = ~nxt_st.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_ff <= ICC_STATE_RST;
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign awready = st_ff.awready;
   assign wready = st_ff.wready;
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign arready = st_ff.arready;
   assign rvalid = st_ff.rvalid;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign capture_irq = st_ff.irq;
   assign cascade_carry = st_ff.carry;
   assign cascade_en_out = st_ff.casc;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_idle_halt: assert property (
      halted |=> $stable(st_ff.cnt) && $stable(st_ff.count))
      else $error("counter or buffer moved while halted in idle");

   chk_pclk_count: assert property (
      run && st_ff.ctrl1[`ICC_C1_CSEL] == `ICC_CK_PCLK && !casc_on
      && !trig_op && !evt |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
      else $error("peripheral clock did not advance the counter");

   chk_held_clear: assert property (
      run && trig_op && !tstat |=> st_ff.cnt == 16'h0000)
      else $error("untriggered counter not held at zero");

   chk_trig_set: assert property (
      run && trig_op && evt |=> st_ff.ctrl2[`ICC_C2_TSTAT])
      else $error("trigger source did not set trigger status");

   chk_ovf_keep: assert property (
      cap && full |=> st_ff.ovf && $stable(st_ff.mem))
      else $error("overflow not flagged or entry overwritten");

   chk_push_ne: assert property (
      push && !pop |=> st_ff.count == $past(st_ff.count) + 3'h1
      && rd_ctrl1[`ICC_C1_NE])
      else $error("capture did not fill the buffer");

   chk_mode_off: assert property (
      mode == `ICC_M_OFF |=> st_ff.count == 3'h0 && !st_ff.ovf)
      else $error("disabled channel kept buffer state");

   chk_fall_only: assert property (
      run && mode == `ICC_M_FALL && rise |-> !cap)
      else $error("falling edge mode captured a rising edge");

   chk_irq_every: assert property (
      cap && st_ff.ctrl1[`ICC_C1_ICI] == 2'h0 |=> capture_irq)
      else $error("single capture interrupt missing");

   chk_pre4_gap: assert property (
      run && mode == `ICC_M_PRE4 && rise && st_ff.pre != `ICC_PRE4_LAST
      |-> !cap)
      else $error("prescaled mode captured too early");

   cov_capture: cover property (push ##1 pop);
   cov_overflow: cover property (cap && full);
   cov_trigger: cover property (run && trig_op && evt);
   cov_wake: cover property (mode == `ICC_M_WAKE && capture_irq);
endmodule

//--- core/icc_map.svh
// register map, field positions, reset values and codes of the capture channel
// assumes byte addressing on a 32-bit register bus
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH
// byte offsets
`define ICC_OFF_CTRL1 8'h00
`define ICC_OFF_CTRL2 8'h04
`define ICC_OFF_BUF 8'h08
`define ICC_OFF_CNT 8'h0c
// capture_control_one fields
`define ICC_C1_STOP 13
`define ICC_C1_CSEL 12:10
`define ICC_C1_ICI 6:5
`define ICC_C1_OVF 4
`define ICC_C1_NE 3
`define ICC_C1_MODE 2:0
`define ICC_C1_WMASK 16'h3c67
`define ICC_C1_RST 16'h0000
// capture_control_two fields
`define ICC_C2_CASC 8
`define ICC_C2_TRIG 7
`define ICC_C2_TSTAT 6
`define ICC_C2_SYNC 4:0
`define ICC_C2_WMASK 16'h01df
`define ICC_C2_RST 16'h000d
// counter clock select codes
`define ICC_CK_PCLK 3'h7
`define ICC_CK_T1 3'h4
`define ICC_CK_T5 3'h3
`define ICC_CK_T4 3'h2
`define ICC_CK_T2 3'h1
`define ICC_CK_T3 3'h0
// edge modes
`define ICC_M_OFF 3'h0
`define ICC_M_EDGE 3'h1
`define ICC_M_FALL 3'h2
`define ICC_M_RISE 3'h3
`define ICC_M_PRE4 3'h4
`define ICC_M_PRE16 3'h5
`define ICC_M_UNUSED 3'h6
`define ICC_M_WAKE 3'h7
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hf
// sync/trigger source code ranges
`define ICC_S_OC1 5'h01
`define ICC_S_OC4 5'h04
`define ICC_S_IC1 5'h05
`define ICC_S_IC4 5'h08
`define ICC_S_T1 5'h0b
`define ICC_S_T2 5'h0c
`define ICC_S_T3 5'h0d
`define ICC_S_T4 5'h0e
`define ICC_S_T5 5'h0f
`define ICC_S_II1 5'h10
`define ICC_S_II4 5'h13
`define ICC_S_COMPARATOR_ONE 5'h18
`define ICC_S_CMP4 5'h1b
// buffer
`define ICC_DEPTH 3'h4
`define ICC_DEPTH_N 4
`define ICC_RESP_OK 2'h0
`define ICC_RESP_ERR 2'h2
`endif

//--- core/icc_pkg.sv
// types of the capture channel
// assumes icc_map.svh is on the include path
`include "icc_map.svh"
package icc_pkg;
   typedef struct packed {
      logic t1;
      logic t2;
      logic t3;
      logic t4;
      logic t5;
      logic [3:0] ic_int;
      logic [3:0] ic_evt;
      logic [3:0] oc_evt;
      logic [3:0] cmp_evt;
   } icc_srcs_s;
   typedef struct packed {
      logic [15:0] ctrl1;
      logic [15:0] ctrl2;
      logic [`ICC_DEPTH_N-1:0][15:0] mem;
      logic [1:0] rd_ptr;
      logic [2:0] count;
      logic ovf;
      logic [15:0] cnt;
      logic [3:0] pre;
      logic [1:0] icnt;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic irq;
      logic carry;
      logic casc;
      logic aw_hold;
      logic w_hold;
      logic [7:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } icc_state_s;
   parameter icc_state_s ICC_STATE_RST =
      '{ctrl1: `ICC_C1_RST, ctrl2: `ICC_C2_RST, default: '0};
endpackage

//--- verification/icc_far.sv
// far side of the capture channel: the capture pin and the sync, trigger and tick sources
// assumes the bench calls its tasks from one process, right after a rising aclk edge
`timescale 1ns/1ps
module icc_far
   import icc_pkg::*;
(
   // clock
   input wire logic aclk,
   // pin and source pulses
   output logic capture_pin,
   output icc_pkg::icc_srcs_s srcs
);
   import icc_pkg::*;

   initial
   begin
      capture_pin = 1'b0;
      srcs = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one-cycle source pulse, same clock as the channel
   task fire(input icc_srcs_s s);
      @(posedge aclk);
      srcs <= s;
      @(posedge aclk);
      srcs <= '0;
   endtask

   // tick of the timer that a clock select code names; 101/110/111 get none
   task tick(input logic [2:0] sel);
      icc_srcs_s s;
      s = '0;
      case (sel)
         3'h0: s.t3 = 1'b1;
         3'h1: s.t2 = 1'b1;
         3'h2: s.t4 = 1'b1;
         3'h3: s.t5 = 1'b1;
         3'h4: s.t1 = 1'b1;
         default: s = '0;
      endcase
      fire(s);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // one tick before each rise, so a capture shows how many pulses went before it
   // pin is held 4 cycles each way: longer than the 2-cycle synchroniser delay
   task pulses(input logic [2:0] sel, input int n);
      repeat (n)
      begin
         tick(sel);
         @(posedge aclk);
         capture_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         capture_pin <= 1'b0;
         repeat (4) @(posedge aclk);
      end
   endtask
endmodule

//--- verification/tb_input_capture_channel.sv
// self-checking bench of the capture channel over AXI4-Lite
// assumes icc_top and icc_far; the far model drives the pin and the sources
`timescale 1ns/1ps
`include "icc_map.svh"
module tb_input_capture_channel;
   import icc_pkg::*;
   typedef struct {int mode; int captures_per_interrupt; int csel; int n; int ncap; int nirq; int ovf; int first;
      int last;} icc_row_s;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, capture_pin, cascade_en_out, capture_irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, v, v2;
   logic cpu_idle = 1'b0, cpu_sleep = 1'b0, partner_cascade = 1'b0, upper_half = 1'b0;
   logic cascade_carry_in = 1'b0;
   logic cascade_carry;
   icc_srcs_s srcs;
   int error_cnt = 0, n_checks = 0, irq_cnt = 0, cyc = 0;
   int carry_cnt = 0;
   // sync words for five source groups, then one comparator used only as a trigger
   logic [15:0] src_codes[6] = '{16'h0001, 16'h0008, 16'h000b, 16'h000d, 16'h0013, 16'h0098};
   icc_srcs_s src_hits[6] = '{'{oc_evt: 4'h1, default: '0}, '{ic_evt: 4'h8, default: '0},
      '{t1: 1'b1, default: '0}, '{t3: 1'b1, default: '0}, '{ic_int: 4'h8, default: '0},
      '{cmp_evt: 4'h1, default: '0}};
   icc_row_s rw;
   // mode, ici, clock select, pulses, captures, irqs (-1 skip), ovf, first, last (-1 skip)
   icc_row_s rows[12] = '{
      '{3, 0, 1, 1, 1, 1, 0, 1, 1},
      '{2, 0, 0, 2, 2, 2, 0, 1, 2},
      '{1, 3, 2, 2, 4, 4, 0, 1, 2},
      '{4, 0, 3, 8, 2, 2, 0, -1, -1},
      '{5, 0, 4, 16, 1, 1, 0, -1, -1},
      '{0, 0, 1, 2, 0, 0, 0, -1, -1},
      '{6, 0, 1, 2, 0, 0, 0, -1, -1},
      '{3, 1, 1, 4, 4, 2, 0, 1, 4},
      '{3, 2, 1, 3, 3, 1, 0, 1, 3},
      '{3, 3, 1, 4, 4, 1, 0, 1, 4},
      '{3, 0, 1, 5, 4, -1, 1, 1, 4},
      '{3, 0, 5, 1, 1, 1, 0, 0, 0}};

   always #10 aclk = ~aclk;

   icc_top i_icc_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .capture_pin(capture_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .srcs(srcs),
      .partner_cascade(partner_cascade), .upper_half(upper_half),
      .cascade_carry_in(cascade_carry_in), .cascade_en_out(cascade_en_out),
      .cascade_carry(cascade_carry), .capture_irq(capture_irq));

   icc_far i_icc_far (.aclk(aclk), .capture_pin(capture_pin), .srcs(srcs));

   ////////////////////////////////////////////////////////////////////////////////
   // irq pulses are counted at the falling edge, away from the launching edge
   always @(negedge aclk)
   begin
      if (capture_irq === 1'b1)
         irq_cnt <= irq_cnt + 1;
      if (cascade_carry === 1'b1)
         carry_cnt <= carry_cnt + 1;
   end

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // handshakes are judged at the falling edge, where ready and valid are settled
   task wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] rs);
      logic aw_hit, w_hit, b_hit;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {16'h0000, d};
      bready <= 1'b1;
      b_hit = 1'b0;
      while (!b_hit)
      begin
         @(negedge aclk);
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid && bready;
         rs = bresp;
         @(posedge aclk);
         if (aw_hit)
            awvalid <= 1'b0;
         if (w_hit)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ar_hit, r_hit;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      r_hit = 1'b0;
      while (!r_hit)
      begin
         @(negedge aclk);
         ar_hit = arvalid && arready;
         r_hit = rvalid && rready;
         d = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ar_hit)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i])
      begin
         rw = rows[i];
         wr(`ICC_OFF_CTRL2, 16'h001f, r);
         wr(`ICC_OFF_CTRL1, 16'(rw.csel << 10), r);
         irq_cnt = 0;
         wr(`ICC_OFF_CTRL1, 16'((rw.csel << 10) | (rw.captures_per_interrupt << 5) | rw.mode), r);
         i_icc_far.pulses(3'(rw.csel), rw.n);
         repeat (6) @(posedge aclk);
         rd(`ICC_OFF_CTRL1, v, r);
         chk("not_empty", 32'(rw.ncap > 0), 32'(v[`ICC_C1_NE]));
         chk("overflow", 32'(rw.ovf), 32'(v[`ICC_C1_OVF]));
         if (rw.nirq >= 0)
            chk("irq_count", 32'(rw.nirq), 32'(irq_cnt));
         for (int k = 0; k < rw.ncap; k++)
         begin
            rd(`ICC_OFF_BUF, v, r);
            if (k == 0 && rw.first >= 0)
               chk("oldest", 32'(rw.first), v);
            if (k == rw.ncap - 1 && rw.last >= 0)
               chk("newest", 32'(rw.last), v);
         end
         rd(`ICC_OFF_CTRL1, v, r);
         chk("drained", 32'h0, 32'(v[`ICC_C1_NE]));
         $display("row %0d done", i);
      end
      // register masks, read-only flags and unmapped words
      wr(`ICC_OFF_CTRL1, 16'hffff, r);
      rd(`ICC_OFF_CTRL1, v, r);
      chk("c1_mask", 32'h3c67, v);
      wr(`ICC_OFF_CTRL2, 16'hffff, r);
      rd(`ICC_OFF_CTRL2, v, r);
      chk("c2_mask", 32'h01df, v);
      chk("casc_out", 32'h1, 32'(cascade_en_out));
      wr(8'h10, 16'h1234, r);
      chk("bresp_bad", 32'h2, 32'(r));
      rd(8'h10, v, r);
      chk("rresp_bad", 32'h2, 32'(r));
      $display("registers done");
      // trigger mode on timer two
      wr(`ICC_OFF_CTRL2, 16'h008c, r);
      wr(`ICC_OFF_CTRL1, 16'h1c03, r);
      repeat (10) @(posedge aclk);
      rd(`ICC_OFF_CNT, v, r);
      chk("held", 32'h0, v);
      i_icc_far.fire('{t2: 1'b1, default: '0});
      rd(`ICC_OFF_CTRL2, v, r);
      chk("trig_set", 32'h00cc, v);
      rd(`ICC_OFF_CNT, v, r);
      rd(`ICC_OFF_CNT, v2, r);
      chk("running", 32'h1, 32'(v2[15:0] > v[15:0]));
      wr(`ICC_OFF_CTRL2, 16'h008c, r);
      rd(`ICC_OFF_CNT, v, r);
      chk("sw_clear", 32'h0, v);
      wr(`ICC_OFF_CTRL2, 16'h00cc, r);
      rd(`ICC_OFF_CTRL2, v, r);
      chk("sw_set", 32'h00cc, v);
      // sync mode on timer four
      wr(`ICC_OFF_CTRL2, 16'h000e, r);
      repeat (100) @(posedge aclk);
      rd(`ICC_OFF_CNT, v, r);
      chk("free_run", 32'h1, 32'(v > 32'h40));
      i_icc_far.fire('{t4: 1'b1, default: '0});
      rd(`ICC_OFF_CNT, v, r);
      chk("synced", 32'h1, 32'(v < 32'h20));
      // a wrong decode leaves the counter far from zero, or held at zero when triggered
      foreach (src_codes[j])
      begin
         wr(`ICC_OFF_CTRL2, src_codes[j], r);
         repeat (100) @(posedge aclk);
         i_icc_far.fire(src_hits[j]);
         rd(`ICC_OFF_CNT, v, r);
         chk("src_restart", 32'h1, 32'(v != 32'h0 && v < 32'h20));
      end
      $display("trigger and sync done");
      // idle stop
      wr(`ICC_OFF_CTRL2, 16'h001f, r);
      wr(`ICC_OFF_CTRL1, 16'h3c03, r);
      cpu_idle <= 1'b1;
      rd(`ICC_OFF_CNT, v, r);
      i_icc_far.pulses(3'h7, 1);
      rd(`ICC_OFF_CNT, v2, r);
      chk("frozen", v, v2);
      rd(`ICC_OFF_CTRL1, v, r);
      chk("no_capture", 32'h3c03, v);
      wr(`ICC_OFF_CTRL1, 16'h1c03, r);
      rd(`ICC_OFF_CNT, v, r);
      rd(`ICC_OFF_CNT, v2, r);
      chk("idle_runs", 32'h1, 32'(v2 != v));
      cpu_idle <= 1'b0;
      // wake mode ignores the capture count
      wr(`ICC_OFF_CTRL1, 16'h0067, r);
      cpu_sleep <= 1'b1;
      irq_cnt = 0;
      i_icc_far.pulses(3'h7, 1);
      repeat (6) @(posedge aclk);
      chk("wake_irq", 32'h1, 32'(irq_cnt));
      rd(`ICC_OFF_CTRL1, v, r);
      chk("wake_nobuf", 32'h0067, v);
      cpu_sleep <= 1'b0;
      $display("idle and wake done");
      // one full lap from zero on the peripheral clock gives exactly one carry
      wr(`ICC_OFF_CTRL1, 16'h1c00, r);
      carry_cnt = 0;
      wr(`ICC_OFF_CTRL1, 16'h1c03, r);
      repeat (65540) @(posedge aclk);
      chk("carry", 32'h1, 32'(carry_cnt));
      // cascaded upper half counts carries
      wr(`ICC_OFF_CTRL1, 16'h1c00, r);
      wr(`ICC_OFF_CTRL2, 16'h011f, r);
      partner_cascade <= 1'b1;
      upper_half <= 1'b1;
      wr(`ICC_OFF_CTRL1, 16'h1c03, r);
      repeat (3)
      begin
         @(posedge aclk);
         cascade_carry_in <= 1'b1;
         @(posedge aclk);
         cascade_carry_in <= 1'b0;
      end
      rd(`ICC_OFF_CNT, v, r);
      chk("upper_cnt", 32'h3, v);
      partner_cascade <= 1'b0;
      upper_half <= 1'b0;
      $display("cascade done");
      // second reset
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ICC_OFF_CTRL1, v, r);
      chk("c1_reset", 32'h0, v);
      rd(`ICC_OFF_CTRL2, v, r);
      chk("c2_reset", 32'h000d, v);
      chk("casc_reset", 32'h0, 32'(cascade_en_out));
      $display("reset done");
      stop_test();
   end
endmodule
